// [hdl/occ_chk.sv]
// Purpose: instruction class check, program exception request, address gen
// Assumes: one instruction word per valid cycle, results one cycle later
// Notes:   no reserved-class instruction is implemented here
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
module occ_chk (
    input  wire logic              i_clk,
    input  wire logic              i_nrst,
    input  wire logic              i_valid,
    input  wire logic [31:0]       i_insn,
    input  wire logic [31:0]       i_pc,
    input  wire logic [31:0]       i_ra_val,
    input  wire logic [31:0]       i_rb_val,
    input  wire logic [31:0]       i_lr,
    input  wire logic [31:0]       i_ctr,
    input  wire logic              i_le_mode,
    input  wire logic              i_user_mode,
    output logic                   o_valid,
    output occ_pkg::occ_class_t    o_class,
    output logic                   o_exc,
    output logic [31:0]            o_exc_pc,
    output logic [31:0]            o_exc_vec,
    output logic                   o_issue,
    output logic                   o_user_mode,
    output logic                   o_is_mem,
    output logic                   o_multi,
    output logic [1:0]             o_size_log,
    output logic [31:0]            o_effective_address,
    output logic [31:0]            o_lane_address,
    output logic                   o_misal,
    output logic                   o_wrap,
    output logic                   o_br_valid,
    output logic [31:0]            o_br_target,
    output logic [31:0]            o_next_seq
);
    import occ_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // opcode tables

    function automatic logic prim_ill(input logic [5:0] op);
        case (op)
            6'h01, 6'h04, 6'h05, 6'h06, 6'h09, 6'h16,
            6'h38, 6'h39, 6'h3C, 6'h3D: prim_ill = 1'b1;
            6'h02, 6'h1E, 6'h3A, 6'h3E: prim_ill = 1'b1;
            default:                    prim_ill = 1'b0;
        endcase
    endfunction

    function automatic logic xo19_ok(input logic [9:0] xo);
        case (xo)
            10'h000, 10'h010, 10'h021, 10'h032, 10'h081,
            10'h096, 10'h0C1, 10'h0E1, 10'h101, 10'h121,
            10'h1A1, 10'h1C1, 10'h210: xo19_ok = 1'b1;
            default:                   xo19_ok = 1'b0;
        endcase
    endfunction

    // arithmetic forms that also exist with the overflow bit set
    function automatic logic oe_ok(input logic [8:0] xo);
        case (xo)
            9'h008, 9'h00A, 9'h028, 9'h068, 9'h088, 9'h08A, 9'h0C8,
            9'h0CA, 9'h0E8, 9'h0EA, 9'h0EB, 9'h10A, 9'h1CB,
            9'h1EB:  oe_ok = 1'b1;
            default: oe_ok = 1'b0;
        endcase
    endfunction

    // tlb-invalidate-all (10'h172) is left out on purpose so it traps
    function automatic logic xo31_ok(input logic [9:0] xo);
        case (xo)
            10'h000, 10'h004, 10'h008, 10'h00A, 10'h00B, 10'h013,
            10'h014, 10'h017, 10'h018, 10'h01A, 10'h01C, 10'h020,
            10'h028, 10'h036, 10'h037, 10'h03C, 10'h04B, 10'h053,
            10'h056, 10'h057, 10'h068, 10'h077, 10'h07C, 10'h088,
            10'h08A, 10'h090, 10'h092, 10'h096, 10'h097, 10'h0B7,
            10'h0C8, 10'h0CA, 10'h0D2, 10'h0D7, 10'h0E8, 10'h0EA,
            10'h0EB, 10'h0F2, 10'h0F6, 10'h0F7, 10'h10A, 10'h116,
            10'h117, 10'h11C, 10'h132, 10'h136, 10'h137, 10'h13C,
            10'h153, 10'h157, 10'h173, 10'h177, 10'h197, 10'h19C,
            10'h1B6, 10'h1B7, 10'h1BC, 10'h1CB, 10'h1D3, 10'h1D6,
            10'h1DC, 10'h1EB, 10'h200, 10'h215, 10'h216, 10'h217,
            10'h218, 10'h236, 10'h237, 10'h253, 10'h255, 10'h256,
            10'h257, 10'h277, 10'h293, 10'h295, 10'h296, 10'h297,
            10'h2B7, 10'h2D5, 10'h2D7, 10'h2F7, 10'h316, 10'h318,
            10'h338, 10'h356, 10'h396, 10'h39A, 10'h3BA, 10'h3D6,
            10'h3D7, 10'h3F6: xo31_ok = 1'b1;
            default:          xo31_ok = 1'b0;
        endcase
    endfunction

    // square roots (5'h16) are absent from both floating tables
    function automatic logic afp_ok(input logic [4:0] xo, input logic dbl);
        case (xo)
            5'h12, 5'h14, 5'h15, 5'h19,
            5'h1C, 5'h1D, 5'h1E, 5'h1F: afp_ok = 1'b1;
            5'h18:                      afp_ok = ~dbl;
            5'h17, 5'h1A:               afp_ok = dbl;
            default:                    afp_ok = 1'b0;
        endcase
    endfunction

    function automatic logic xfp_ok(input logic [9:0] xo);
        case (xo)
            10'h000, 10'h00C, 10'h00E, 10'h00F, 10'h020,
            10'h026, 10'h028, 10'h040, 10'h046, 10'h048,
            10'h086, 10'h088, 10'h108, 10'h247,
            10'h2C7: xfp_ok = 1'b1;
            default: xfp_ok = 1'b0;
        endcase
    endfunction

    // indexed memory forms: size and whether the form accesses memory
    function automatic logic [1:0] x_size(input logic [9:0] xo);
        case (xo)
            10'h057, 10'h077, 10'h0D7, 10'h0F7,
            10'h215, 10'h255, 10'h295, 10'h2D5: x_size = SZ_BYTE;
            10'h117, 10'h137, 10'h157, 10'h177,
            10'h197, 10'h1B7, 10'h316, 10'h396: x_size = SZ_HALF;
            10'h257, 10'h277, 10'h2D7, 10'h2F7: x_size = SZ_DBL;
            default:                            x_size = SZ_WORD;
        endcase
    endfunction

    function automatic logic x_mem(input logic [9:0] xo);
        case (xo)
            10'h014, 10'h017, 10'h037, 10'h057, 10'h077, 10'h096,
            10'h097, 10'h0B7, 10'h0D7, 10'h0F7, 10'h117, 10'h137,
            10'h157, 10'h177, 10'h197, 10'h1B7, 10'h215, 10'h216,
            10'h217, 10'h237, 10'h255, 10'h257, 10'h277, 10'h295,
            10'h296, 10'h297, 10'h2B7, 10'h2D5, 10'h2D7, 10'h2F7,
            10'h316, 10'h396, 10'h3D7: x_mem = 1'b1;
            default:                  x_mem = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // field decode

    wire logic [5:0]  prim;
    wire logic [9:0]  xo10;
    wire logic [4:0]  xo5;
    wire logic        is_zero;
    wire logic        xo_ok;
    wire logic        has_xo;
    occ_class_t       next_class;
    wire logic        next_exc;

    // the word is taken whole; instructions are always one aligned word
    assign prim    = i_insn[31:26];
    assign xo10    = i_insn[10:1];
    assign xo5     = i_insn[5:1];
    assign is_zero = (i_insn == OCC_ZERO_INSN);

    assign has_xo = (prim == OP_SC) || (prim == OP_X19) || (prim == OP_X31) ||
                    (prim == OP_FS) || (prim == OP_FD);

    // system call needs its fixed one bit; other primaries check their tables
    assign xo_ok =
        (prim == OP_SC)  ? i_insn[1] :
        (prim == OP_X19) ? xo19_ok(xo10) :
        (prim == OP_X31) ? (xo31_ok(xo10) || (xo10[9] && oe_ok(xo10[8:0]))) :
        (prim == OP_FS)  ? (xo5 >= XO5_AFORM) && afp_ok(xo5, 1'b0) :
        (xo5 >= XO5_AFORM) ? afp_ok(xo5, 1'b1) : xfp_ok(xo10);

    always_comb begin
        if (is_zero) begin
            next_class = CL_ILL;
        end else if (prim == OP_ZERO) begin
            next_class = CL_RSVD;
        end else if (prim_ill(prim)) begin
            next_class = CL_ILL;
        end else if (has_xo && !xo_ok) begin
            next_class = CL_ILL;
        end else begin
            next_class = CL_DEF;
        end
    end

    // no reserved-class instruction is built in, so every one traps
    assign next_exc = i_valid && (next_class != CL_DEF);

    ////////////////////////////////////////////////////////////////////////
    // memory operand decode

    wire logic        d_mem;
    wire logic        xm_mem;
    wire logic        is_str;
    wire logic        next_mem;
    wire logic        next_multi;
    logic [1:0]       next_size;
    occ_agen_mode_t   agen_mode;
    wire logic [31:0] disp;

    assign d_mem  = (prim >= OP_MEM_LO) && (prim <= OP_MEM_HI);
    assign xm_mem = (prim == OP_X31) && x_mem(xo10);
    assign is_str = (prim == OP_X31) &&
                    ((xo10 == XO_LSWI) || (xo10 == XO_STSWI) ||
                     (xo10 == 10'h215) || (xo10 == 10'h295));
    assign next_mem   = (d_mem || xm_mem) && (next_class == CL_DEF);
    assign next_multi = (prim == OP_LMW) || (prim == OP_STMW) || is_str;
    assign disp = {{16{i_insn[15]}}, i_insn[15:0]};

    always_comb begin
        next_size = SZ_WORD;
        case (prim)
            6'h22, 6'h23, 6'h26, 6'h27: next_size = SZ_BYTE;
            6'h28, 6'h29, 6'h2A, 6'h2B,
            6'h2C, 6'h2D:               next_size = SZ_HALF;
            6'h32, 6'h33, 6'h36, 6'h37: next_size = SZ_DBL;
            OP_X31:                     next_size = x_size(xo10);
            default:                    next_size = SZ_WORD;
        endcase
    end

    // immediate strings use the base register alone
    always_comb begin
        if (d_mem) begin
            agen_mode = AG_IMM;
        end else if (xo10 == XO_LSWI || xo10 == XO_STSWI) begin
            agen_mode = AG_REG;
        end else begin
            agen_mode = AG_IDX;
        end
    end

    occ_agen_if eaif ();

    assign eaif.mode     = agen_mode;
    assign eaif.base     = i_ra_val;
    assign eaif.index    = i_rb_val;
    assign eaif.disp     = disp;
    assign eaif.size_log = next_size;
    assign eaif.le       = i_le_mode;

    occ_agen u_agen (
        .eaif (eaif)
    );

    ////////////////////////////////////////////////////////////////////////
    // branch targets

    occ_br_mode_t     br_mode;
    wire logic [31:0] br_disp;
    wire logic [31:0] br_rel;
    logic [31:0]      next_target;
    wire logic [31:0] seq_pc;

    always_comb begin
        if (prim == OP_B || prim == OP_BC) begin
            br_mode = BR_IMM;
        end else if (prim == OP_X19 && xo10 == XO_BCLR) begin
            br_mode = BR_LR;
        end else if (prim == OP_X19 && xo10 == XO_BCCTR) begin
            br_mode = BR_CTR;
        end else begin
            br_mode = BR_NONE;
        end
    end

    assign br_disp = (prim == OP_B) ?
                     {{6{i_insn[25]}}, i_insn[25:2], 2'h0} :
                     {{16{i_insn[15]}}, i_insn[15:2], 2'h0};
    assign br_rel = occ_add32(i_pc, br_disp);
    assign seq_pc = occ_add32(i_pc, OCC_INSN_BYTES);

    always_comb begin
        case (br_mode)
            BR_IMM:  next_target = i_insn[1] ? br_disp : br_rel;
            BR_LR:   next_target = {i_lr[31:2], 2'h0};
            BR_CTR:  next_target = {i_ctr[31:2], 2'h0};
            default: next_target = seq_pc;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // result registers

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_valid     <= 1'b0;
            o_class     <= CL_DEF;
            o_exc       <= 1'b0;
            o_exc_pc    <= OCC_RST_WORD;
            o_exc_vec   <= OCC_RST_WORD;
            o_issue     <= 1'b0;
            o_user_mode <= 1'b0;
        end else begin
            o_valid     <= i_valid;
            o_class     <= next_class;
            o_exc       <= next_exc;
            o_exc_pc    <= next_exc ? i_pc : OCC_RST_WORD;
            o_exc_vec   <= next_exc ? OCC_PROG_VEC : OCC_RST_WORD;
            o_issue     <= i_valid && !next_exc;
            // outside reset the checker never grants supervisor state; it only passes it on
            o_user_mode <= i_user_mode;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_is_mem    <= 1'b0;
            o_multi     <= 1'b0;
            o_size_log  <= SZ_BYTE;
            o_effective_address <= OCC_RST_WORD;
            o_lane_address      <= OCC_RST_WORD;
            o_misal     <= 1'b0;
            o_wrap      <= 1'b0;
            o_br_valid  <= 1'b0;
            o_br_target <= OCC_RST_WORD;
            o_next_seq  <= OCC_RST_WORD;
        end else begin
            o_is_mem    <= i_valid && next_mem;
            o_multi     <= next_multi;
            o_size_log  <= next_size;
            o_effective_address <= eaif.effective_address;
            o_lane_address      <= eaif.lane_address;
            o_misal     <= eaif.misal;
            o_wrap      <= eaif.wrap;
            o_br_valid  <= i_valid && !next_exc && (br_mode != BR_NONE);
            o_br_target <= next_target;
            o_next_seq  <= seq_pc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    zero_word_a: assert property (
        i_valid && i_insn == OCC_ZERO_INSN |=> o_exc && o_class == CL_ILL)
        else $error("all-zero word not trapped");

    prim_illeg_a: assert property (
        i_valid && (i_insn[31:26] == 6'h16 || i_insn[31:26] == 6'h39)
        |=> o_exc && !o_issue)
        else $error("illegal primary opcode not trapped");

    wide_prim_a: assert property (
        i_valid && i_insn[31:26] == 6'h1E |=> o_class == CL_ILL ##0 o_exc)
        else $error("64-bit primary opcode not trapped");

    rsvd_class_a: assert property (
        i_valid && i_insn[31:26] == OP_ZERO && i_insn != OCC_ZERO_INSN
        |=> o_class == CL_RSVD && o_exc_vec == OCC_PROG_VEC)
        else $error("reserved word misclassed");

    sqrt_trap_a: assert property (
        i_valid && i_insn[31:26] == OP_FD && i_insn[5:1] == 5'h16 |=> o_exc)
        else $error("square root not trapped");

    fault_pc_a: assert property (
        i_valid ##1 o_exc |-> o_exc_pc == $past(i_pc) && !o_br_valid && !o_is_mem)
        else $error("fault address or suppression wrong");

    user_keep_a: assert property (
        i_user_mode |=> o_user_mode)
        else $error("user state lost");

    seq_fetch_a: assert property (
        i_valid && i_pc == 32'hFFFF_FFFC |=> o_next_seq == 32'h0000_0000)
        else $error("sequential address did not wrap");

    misal_word_a: assert property (
        i_valid && i_insn[31:26] == OP_MEM_LO && i_ra_val[1:0] == 2'h0 &&
        i_insn[1:0] == 2'h2 |=> o_misal && o_size_log == SZ_WORD)
        else $error("misaligned word not flagged");

    wrap_word_a: assert property (
        i_valid && i_insn[31:26] == OP_MEM_LO && i_insn[15:0] == 16'h0 &&
        i_ra_val == 32'hFFFF_FFFE |=> o_wrap)
        else $error("wrapping operand not flagged");

    lr_target_a: assert property (
        i_valid && i_insn[31:26] == OP_X19 && i_insn[10:1] == XO_BCLR
        |=> o_br_valid && o_br_target == {$past(i_lr[31:2]), 2'h0})
        else $error("link register target wrong");

    cov_ill_c:   cover property (o_valid && o_class == CL_ILL);
    cov_rsvd_c:  cover property (o_valid && o_class == CL_RSVD);
    cov_misal_c: cover property (o_is_mem && o_misal);
    cov_wrap_c:  cover property (o_is_mem && o_wrap);

endmodule
`default_nettype wire

// [hdl/occ_ea_gen.sv]
// Purpose: effective address, alignment, wrap and lane swizzle
// Assumes: operand size is a power of two up to eight bytes
// Notes:   combinational; the decoder registers the results
`timescale 1ns/1ps
`default_nettype none
module occ_agen (
    occ_agen_if.gen eaif
);
    import occ_pkg::*;

    wire logic [31:0] sum_imm;
    wire logic [31:0] sum_idx;
    wire logic [31:0] effective_address;
    wire logic [2:0]  mask;
    wire logic [31:0] last;

    assign sum_imm = occ_add32(eaif.base, eaif.disp);
    assign sum_idx = occ_add32(eaif.base, eaif.index);
    assign effective_address = (eaif.mode == AG_IMM) ? sum_imm :
                               (eaif.mode == AG_IDX) ? sum_idx : eaif.base;
    assign mask = 3'((4'h1 << eaif.size_log) - 4'h1);
    // last byte is the first plus length minus one; a smaller value means it wrapped
    assign last = occ_add32(effective_address, {29'h0, mask});
    assign eaif.wrap = (last < effective_address);
    assign eaif.misal = |(effective_address[2:0] & mask);
    // little-endian mode flips the low address bits inside the doubleword
    assign eaif.lane_address = eaif.le ?
        {effective_address[31:3], effective_address[2:0] ^ (3'h7 & ~mask)} :
        effective_address;
    assign eaif.effective_address = effective_address;

endmodule
`default_nettype wire

// [pkg/occ_ea_if.sv]
// Purpose: carrier between decoder and effective address unit
// Assumes: single clock, purely combinational path
// Notes:   gen side computes, use side supplies operands
`timescale 1ns/1ps
`default_nettype none
interface occ_agen_if;
    import occ_pkg::*;
    occ_agen_mode_t mode;
    logic [31:0]    base;
    logic [31:0]    index;
    logic [31:0]    disp;
    logic [1:0]     size_log;
    logic           le;
    logic [31:0]    effective_address;
    logic [31:0]    lane_address;
    logic           misal;
    logic           wrap;
    modport gen (input mode, base, index, disp, size_log, le,
                 output effective_address, lane_address, misal, wrap);
    modport drv (output mode, base, index, disp, size_log, le,
                 input effective_address, lane_address, misal, wrap);
endinterface
`default_nettype wire

// [pkg/occ_pkg.sv]
// Purpose: shared types and constants of the opcode class checker
// Assumes: 32-bit core, big-endian bit numbering mapped to [31:0]
// Notes:   address arithmetic helper drops the carry out of bit 31
`default_nettype none
package occ_pkg;

    typedef enum logic [1:0] {CL_DEF, CL_ILL, CL_RSVD} occ_class_t;
    typedef enum logic [1:0] {AG_IMM, AG_IDX, AG_REG} occ_agen_mode_t;
    typedef enum logic [1:0] {BR_IMM, BR_LR, BR_CTR, BR_NONE} occ_br_mode_t;

    localparam logic [31:0] OCC_PROG_VEC   = 32'h0000_0700;
    localparam logic [31:0] OCC_INSN_BYTES = 32'h0000_0004;
    localparam logic [31:0] OCC_RST_WORD   = 32'h0000_0000;
    localparam logic [31:0] OCC_ZERO_INSN  = 32'h0000_0000;

    // primary opcodes
    localparam logic [5:0] OP_ZERO  = 6'h00;
    localparam logic [5:0] OP_BC    = 6'h10;
    localparam logic [5:0] OP_SC    = 6'h11;
    localparam logic [5:0] OP_B     = 6'h12;
    localparam logic [5:0] OP_X19   = 6'h13;
    localparam logic [5:0] OP_X31   = 6'h1F;
    localparam logic [5:0] OP_FS    = 6'h3B;
    localparam logic [5:0] OP_FD    = 6'h3F;
    localparam logic [5:0] OP_MEM_LO = 6'h20;
    localparam logic [5:0] OP_MEM_HI = 6'h37;
    localparam logic [5:0] OP_LMW   = 6'h2E;
    localparam logic [5:0] OP_STMW  = 6'h2F;

    // extended opcodes
    localparam logic [9:0] XO_BCLR  = 10'h010;
    localparam logic [9:0] XO_BCCTR = 10'h210;
    localparam logic [9:0] XO_LSWI  = 10'h255;
    localparam logic [9:0] XO_STSWI = 10'h2D5;
    localparam logic [4:0] XO5_AFORM = 5'h10;

    // operand size as log2 of the byte count
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [1:0] SZ_DBL  = 2'h3;

    function automatic logic [31:0] occ_add32(input logic [31:0] a,
                                              input logic [31:0] b);
        logic [32:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[31:0];
    endfunction

endpackage
`default_nettype wire

// [verif/occ_chk_test.sv]
// Purpose: self-checking bench of the opcode class checker
// Assumes: results show one cycle after the word is taken
// Notes:   link and count registers share the base and index lines
`timescale 1ns/1ps
`default_nettype none
module occ_chk_test;
    import occ_pkg::*;
    logic        i_clk, i_nrst, i_valid, i_le_mode, i_user_mode;
    logic [31:0] i_insn, i_pc, i_ra_val, i_rb_val;
    logic        o_valid, o_exc, o_issue, o_user_mode, o_is_mem, o_multi;
    logic        o_misal, o_wrap, o_br_valid;
    logic [31:0] o_exc_pc, o_exc_vec, o_effective_address, o_lane_address;
    logic [31:0] o_br_target, o_next_seq;
    logic [1:0]  o_size_log;
    occ_class_t  o_class;
    int          mismatches, checks, cycles;
`define OCC_CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end

    occ_fetch_model fetch_u (.i_clk, .o_valid(i_valid), .o_insn(i_insn), .o_pc(i_pc),
        .o_a(i_ra_val), .o_b(i_rb_val), .o_le(i_le_mode), .o_user(i_user_mode));
    occ_chk dut_u (.i_clk, .i_nrst, .i_valid, .i_insn, .i_pc, .i_ra_val, .i_rb_val,
        .i_lr(i_ra_val), .i_ctr(i_rb_val), .i_le_mode, .i_user_mode, .o_valid, .o_class,
        .o_exc, .o_exc_pc, .o_exc_vec, .o_issue, .o_user_mode, .o_is_mem, .o_multi,
        .o_size_log, .o_effective_address, .o_lane_address, .o_misal, .o_wrap,
        .o_br_valid, .o_br_target, .o_next_seq);

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    // a hang costs at most two thousand cycles
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic go(input logic [31:0] insn, pc, a, b, input logic le, usr);
        fetch_u.send(insn, pc, a, b, le, usr);
        #1;
        `OCC_CHK("valid", 1'b1, o_valid)
        `OCC_CHK("user", usr, o_user_mode)
    endtask

    task automatic ill(input logic [31:0] insn, pc, input occ_class_t cls);
        go(insn, pc, ~pc, pc, 1'b0, 1'b1);
        `OCC_CHK("class", cls, o_class)
        `OCC_CHK("exc", 1'b1, o_exc)
        `OCC_CHK("vec", OCC_PROG_VEC, o_exc_vec)
        `OCC_CHK("exc_pc", pc, o_exc_pc)
        `OCC_CHK("issue", 1'b0, o_issue)
        `OCC_CHK("is_mem", 1'b0, o_is_mem)
    endtask

    task automatic mem(input logic [31:0] insn, a, b, input logic le,
                       input logic [1:0] sz, input logic [31:0] addr, input logic multi);
        logic [32:0] last;
        logic [2:0]  swz;
        last = {1'b0, addr} + (33'h1 << sz) - 33'h1;
        swz = le ? 3'h7 << sz : 3'h0;
        go(insn, 32'h40, a, b, le, 1'b0);
        `OCC_CHK("issue", 1'b1, o_issue)
        `OCC_CHK("is_mem", 1'b1, o_is_mem)
        `OCC_CHK("multi", multi, o_multi)
        `OCC_CHK("size", sz, o_size_log)
        `OCC_CHK("addr", addr, o_effective_address)
        `OCC_CHK("lane", addr ^ {29'h0, swz}, o_lane_address)
        `OCC_CHK("misal", |(addr[2:0] & ~(3'h7 << sz)), o_misal)
        `OCC_CHK("wrap", last[32], o_wrap)
    endtask

    task automatic br(input logic [31:0] insn, pc, a, b, tgt);
        go(insn, pc, a, b, 1'b1, 1'b0);
        `OCC_CHK("br_valid", 1'b1, o_br_valid)
        `OCC_CHK("target", tgt, o_br_target)
        `OCC_CHK("next", pc + 32'h4, o_next_seq)
        `OCC_CHK("exc", 1'b0, o_exc)
    endtask

    task automatic t_illegal();
        byte unsigned ops[14] = '{1, 4, 5, 6, 9, 22, 56, 57, 60, 61, 2, 30, 58, 62};
        foreach (ops[k]) ill({ops[k][5:0], 26'h0ABC}, 32'(k) << 2, CL_ILL);
        ill(32'h0, 32'hFFFF_FFFC, CL_ILL);
        ill(32'h0000_0200, 32'h200, CL_RSVD);
        $display("test illegal done");
    endtask

    task automatic t_ext();
        ill({6'd17, 26'h0}, 32'h10, CL_ILL);
        ill({6'd19, 15'h0, 10'd1, 1'b0}, 32'h14, CL_ILL);
        ill({6'd31, 15'h0, 10'd21, 1'b0}, 32'h18, CL_ILL);
        ill({6'd59, 15'h0, 10'd2, 1'b0}, 32'h1C, CL_ILL);
        ill({6'd63, 15'h0, 10'd22, 1'b0}, 32'h20, CL_ILL);
        ill({6'd59, 15'h0, 10'd22, 1'b0}, 32'h24, CL_ILL);
        ill({6'd31, 15'h0, 10'd370, 1'b0}, 32'h28, CL_ILL);
        $display("test extended done");
    endtask

    task automatic t_mem();
        mem(32'h8003_0002, 32'h1000, 32'h0, 1'b0, 2'h2, 32'h1002, 1'b0);
        mem(32'h8003_0008, 32'hFFFF_FFFC, 32'h0, 1'b0, 2'h2, 32'h4, 1'b0);
        mem(32'h8003_0000, 32'hFFFF_FFFE, 32'h0, 1'b0, 2'h2, 32'hFFFF_FFFE, 1'b0);
        mem(32'h8803_FFFF, 32'h10, 32'h0, 1'b1, 2'h0, 32'hF, 1'b0);
        mem(32'hA003_0004, 32'h20, 32'h0, 1'b1, 2'h1, 32'h24, 1'b0);
        mem(32'hC803_0008, 32'h104, 32'h0, 1'b1, 2'h3, 32'h10C, 1'b0);
        mem(32'h7C61_102E, 32'h300, 32'h5, 1'b0, 2'h2, 32'h305, 1'b0);
        mem(32'h7C61_24AA, 32'h400, 32'h9, 1'b0, 2'h0, 32'h400, 1'b1);
        mem(32'hBB81_0010, 32'h500, 32'h0, 1'b0, 2'h2, 32'h510, 1'b1);
        $display("test memory done");
    endtask

    task automatic t_branch();
        br(32'h4800_0402, 32'h800, 32'h0, 32'h0, 32'h400);
        br(32'h4800_0400, 32'h800, 32'h0, 32'h0, 32'hC00);
        br(32'h4E80_0020, 32'hFFFF_FFFC, 32'h2003, 32'h0, 32'h2000);
        br(32'h4E80_0420, 32'h900, 32'h0, 32'h3007, 32'h3004);
        @(posedge i_clk);
        #1;
        `OCC_CHK("idle", 1'b0, o_valid | o_exc | o_issue | o_br_valid)
        $display("test branch done");
    endtask

    initial begin
        i_nrst = 1'b0;
        repeat (4) @(posedge i_clk);
        #1;
        `OCC_CHK("rst", 1'b0, o_valid | o_exc)
        @(posedge i_clk);
        i_nrst <= 1'b1;
        t_illegal();
        t_ext();
        t_mem();
        t_branch();
        final_report();
    end
endmodule
`default_nettype wire

// [verif/occ_fetch_model.sv]
// Purpose: fetch and dispatch stand-in, one word per request
// Assumes: the checker takes a word at the edge where valid is high
// Notes:   data lines flip once taken, so stale values never look good
`timescale 1ns/1ps
`default_nettype none
module occ_fetch_model (
    input  wire logic        i_clk,
    output logic             o_valid,
    output logic [31:0]      o_insn,
    output logic [31:0]      o_pc,
    output logic [31:0]      o_a,
    output logic [31:0]      o_b,
    output logic             o_le,
    output logic             o_user
);
    initial begin
        o_valid = 1'b0;
        {o_insn, o_pc, o_a, o_b, o_le, o_user} = '0;
    end

    // a whole 32-bit word per request
    task automatic send(input logic [31:0] insn, pc, a, b, input logic le, usr);
        @(posedge i_clk);
        o_valid <= 1'b1;
        {o_insn, o_pc, o_a, o_b, o_le, o_user} <= {insn, pc, a, b, le, usr};
        @(posedge i_clk);
        o_valid <= 1'b0;
        {o_insn, o_pc, o_a, o_b, o_le, o_user} <= ~{insn, pc, a, b, le, usr};
    endtask
endmodule
`default_nettype wire
